/* hdl/cix_pkg.sv */
// Package for the instruction execution subset: opcodes, timing, resets.
// Assumes 16-bit instruction words and an 8-bit data path.
`default_nettype none
package cix_pkg;
   localparam logic [6:0]  OP_COMPLEMENT_FILE_INSTR       = 7'h09;   // 0001 001d
   localparam logic [6:0]  OP_ROTATE_RIGHT_NOCARRY_INSTR      = 7'h10;   // 0010 000d
   localparam logic [15:0] OP_CLEAR_WATCHDOG_INSTR     = 16'h0004;
   localparam logic [7:0]  OP_LONG_CALL_INSTR      = 8'hB7;
   localparam int          DEST_BIT      = 8;
   localparam logic [7:0]  WDOG_CLR_VAL  = 8'h00;
   localparam logic [7:0]  ZERO_BYTE     = 8'h00;
   localparam logic [15:0] PC_RESET      = 16'h0000;
   localparam logic [1:0]  CYC_ONE       = 2'h1;
   localparam logic [1:0]  CYC_TWO       = 2'h2;
   localparam logic [1:0]  CYC_THREE     = 2'h3;
   localparam logic [1:0]  CYC_EXT_TBLWT = 2'h2;

   typedef enum logic [3:0] {
      CIX_IDLE = 4'h1,
      CIX_EXEC = 4'h2,
      CIX_PROG = 4'h4,
      CIX_DONE = 4'h8
   } cix_state_type;

   // Zero flag of an 8-bit result
   function automatic logic cix_is_zero(input logic [7:0] v);
      return v == ZERO_BYTE;
   endfunction
endpackage
`default_nettype wire

/* hdl/cix_cycle_cnt.sv */
// Counter of instruction cycles left for the current instruction.
// Assumes load and tick from the decoder, single clock.
`default_nettype none
module cix_cycle_cnt
   import cix_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rstn,
   // Control
   input  wire logic       load,
   input  wire logic [1:0] load_val,
   input  wire logic       tick,
   // Status
   output logic            last
);
   logic [1:0] cnt_reg;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_reg <= 2'h0;
      end else if (load) begin
         cnt_reg <= load_val;
      end else if (tick && cnt_reg != 2'h0) begin
         cnt_reg <= cnt_reg - 2'h1;
      end
   end

   assign last = (cnt_reg == CYC_ONE) && tick;
endmodule
`default_nettype wire

/* hdl/cix_exec.sv */
// Execution unit for a subset of an 8-bit core's instructions.
// Assumes one instruction issued per issue pulse; operands come in ready.
`default_nettype none
// Behaviour
// - With s=1 the result goes to the file only, with s=0 to both file and accumulator.
// - A long call loads the high latch into the upper pc byte and the literal into the low byte.
// - Table write to internal memory programs until an interrupt, to external memory takes two cycles.
// - A test-and-skip takes two cycles when its condition holds and one otherwise.
// - Flow and table-read instructions take two cycles, a table read into the pc low byte three.
// - A taken skip drops the prefetched instruction and runs a no-operation in its place.
// - Clear watchdog zeroes watchdog counter and postscaler and sets both active-low flags.
// - Complement inverts the register, writes accumulator on d=0 or file on d=1, updates zero.
module cix_exec
   import cix_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // Instruction issue
   input  wire logic        issue,
   input  wire logic [15:0] instr,
   input  wire logic [7:0]  file_rd_data,
   input  wire logic        dest_sel_both,
   input  wire logic        is_skip,
   input  wire logic        skip_cond,
   input  wire logic        is_flow,
   input  wire logic        is_tblrd_pcl,
   input  wire logic        is_tblwt,
   input  wire logic        tblwt_internal,
   input  wire logic        irq_event,
   input  wire logic [7:0]  pc_high_latch,
   // Results
   output logic             busy,
   output logic             flush_fetch,
   output logic [7:0]       accumulator,
   output logic [7:0]       file_wr_data,
   output logic             file_wr_en,
   output logic [15:0]      pc_reg,
   output logic             zero_flag,
   output logic [7:0]       wdog_count,
   output logic [7:0]       wdog_postscale,
   output logic             wdog_expiry_n,
   output logic             sleep_flag_n
);
   cix_state_type state_reg;
   cix_state_type state_next;
   logic          dbit;
   logic          is_complement_file_instr;
   logic          is_rotate_right_nocarry_instr;
   logic          is_clear_watchdog_instr;
   logic          is_long_call_instr;
   logic [7:0]    alu_res;
   logic [1:0]    cyc_len;
   logic          multi;
   logic          cnt_last;

   assign dbit      = instr[DEST_BIT];
   assign is_complement_file_instr   = instr[15:9] == OP_COMPLEMENT_FILE_INSTR;
   assign is_rotate_right_nocarry_instr  = instr[15:9] == OP_ROTATE_RIGHT_NOCARRY_INSTR;
   assign is_clear_watchdog_instr = instr == OP_CLEAR_WATCHDOG_INSTR;
   assign is_long_call_instr  = instr[15:8] == OP_LONG_CALL_INSTR;

   always_comb begin
      alu_res = file_rd_data;
      if (is_complement_file_instr) begin
         alu_res = ~file_rd_data;
      end else if (is_rotate_right_nocarry_instr) begin
         alu_res = {file_rd_data[0], file_rd_data[7:1]};
      end
   end

   always_comb begin
      cyc_len = CYC_ONE;
      if (is_skip && skip_cond) begin
         cyc_len = CYC_TWO;
      end else if (is_tblrd_pcl) begin
         cyc_len = CYC_THREE;
      end else if (is_flow || is_long_call_instr) begin
         cyc_len = CYC_TWO;
      end else if (is_tblwt && !tblwt_internal) begin
         cyc_len = CYC_EXT_TBLWT;
      end
   end

   assign multi = cyc_len != CYC_ONE;

   cix_cycle_cnt u_cnt (
      .clk      (clk),
      .rstn     (rstn),
      .load     (issue && state_reg == CIX_IDLE),
      // Issue cycle is the first cycle, so busy runs one fewer
      .load_val (2'(cyc_len - CYC_ONE)),
      .tick     (state_reg == CIX_EXEC),
      .last     (cnt_last)
   );

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         CIX_IDLE: begin
            if (issue && is_tblwt && tblwt_internal) begin
               state_next = CIX_PROG;
            end else if (issue && multi) begin
               state_next = CIX_EXEC;
            end
         end
         CIX_EXEC: begin
            if (cnt_last) begin
               state_next = CIX_DONE;
            end
         end
         CIX_PROG: begin
            if (irq_event) begin
               state_next = CIX_DONE;
            end
         end
         CIX_DONE: state_next = CIX_IDLE;
         default:  state_next = CIX_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= CIX_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Busy covers the extra cycles; the first cycle is the issue cycle
   assign busy = state_reg != CIX_IDLE && state_reg != CIX_DONE;
   // Prefetched slot becomes a no-operation
   assign flush_fetch = issue && state_reg == CIX_IDLE
                        && is_skip && skip_cond;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         accumulator  <= ZERO_BYTE;
         file_wr_data <= ZERO_BYTE;
         file_wr_en   <= 1'b0;
      end else begin
         file_wr_en <= 1'b0;
         if (issue && state_reg == CIX_IDLE && (is_complement_file_instr || is_rotate_right_nocarry_instr)) begin
            // Complement and rotate: d=0 to accumulator, d=1 to file
            if (dbit) begin
               file_wr_data <= alu_res;
               file_wr_en   <= 1'b1;
            end else begin
               accumulator <= alu_res;
            end
         end else if (issue && state_reg == CIX_IDLE && !is_clear_watchdog_instr
                      && !is_long_call_instr && !is_skip) begin
            // Generic s-operand path: file always, accumulator on 0
            file_wr_data <= alu_res;
            file_wr_en   <= 1'b1;
            if (!dest_sel_both) begin
               accumulator <= alu_res;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         zero_flag <= 1'b0;
      end else if (issue && state_reg == CIX_IDLE && is_complement_file_instr) begin
         zero_flag <= cix_is_zero(alu_res);
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pc_reg <= PC_RESET;
      end else if (issue && state_reg == CIX_IDLE && is_long_call_instr) begin
         pc_reg <= {pc_high_latch, instr[7:0]};
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wdog_count     <= WDOG_CLR_VAL;
         wdog_postscale <= WDOG_CLR_VAL;
         wdog_expiry_n  <= 1'b1;
         sleep_flag_n   <= 1'b1;
      end else if (issue && state_reg == CIX_IDLE && is_clear_watchdog_instr) begin
         wdog_count     <= WDOG_CLR_VAL;
         wdog_postscale <= WDOG_CLR_VAL;
         wdog_expiry_n  <= 1'b1;
         sleep_flag_n   <= 1'b1;
      end else begin
         wdog_count <= wdog_count + 8'h01;
         if (&wdog_count) begin
            // Postscaler advances once per counter wrap
            wdog_postscale <= wdog_postscale + 8'h01;
         end
      end
   end

   logic idle_issue;
   assign idle_issue = issue && state_reg == CIX_IDLE;

   property p_long_call_instr;
      @(posedge clk) disable iff (!rstn)
      idle_issue && is_long_call_instr |=> pc_reg == {$past(pc_high_latch),
                                            $past(instr[7:0])};
   endproperty
   a_long_call_instr: assert property (p_long_call_instr) else $error("long call pc wrong");

   property p_complement_file_instr;
      @(posedge clk) disable iff (!rstn)
      idle_issue && is_complement_file_instr && !dbit |=> accumulator == ~$past(file_rd_data);
   endproperty
   a_complement_file_instr: assert property (p_complement_file_instr) else $error("complement wrong");

   property p_rotate_right_nocarry_instr;
      @(posedge clk) disable iff (!rstn)
      idle_issue && is_rotate_right_nocarry_instr && dbit |=> file_wr_en
         && file_wr_data == {$past(file_rd_data[0]), $past(file_rd_data[7:1])};
   endproperty
   a_rotate_right_nocarry_instr: assert property (p_rotate_right_nocarry_instr) else $error("rotate wrong");

   property p_zero;
      @(posedge clk) disable iff (!rstn)
      idle_issue && is_complement_file_instr |=> zero_flag == ($past(file_rd_data) == 8'hFF);
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");

   property p_clear_watchdog_instr;
      @(posedge clk) disable iff (!rstn)
      idle_issue && is_clear_watchdog_instr |=> wdog_count == 8'h00 && wdog_postscale == 8'h00
         && wdog_expiry_n && sleep_flag_n;
   endproperty
   a_clear_watchdog_instr: assert property (p_clear_watchdog_instr) else $error("watchdog clear");

   property p_skip;
      @(posedge clk) disable iff (!rstn)
      idle_issue && is_skip |-> flush_fetch == skip_cond ##1 !file_wr_en;
   endproperty
   a_skip: assert property (p_skip) else $error("skip flush wrong");

   property p_two;
      @(posedge clk) disable iff (!rstn)
      idle_issue && is_flow && !is_tblrd_pcl && !(is_skip && skip_cond)
         |=> busy ##1 !busy;
   endproperty
   a_two: assert property (p_two) else $error("two-cycle wrong");

   property p_three;
      @(posedge clk) disable iff (!rstn)
      idle_issue && is_tblrd_pcl && !(is_skip && skip_cond)
         |=> busy [*2] ##1 !busy;
   endproperty
   a_three: assert property (p_three) else $error("three-cycle wrong");

   property p_skip_one;
      @(posedge clk) disable iff (!rstn)
      idle_issue && is_skip && !skip_cond && !is_flow && !is_tblrd_pcl
         && !is_tblwt && !is_long_call_instr |=> !busy;
   endproperty
   a_skip_one: assert property (p_skip_one) else $error("skip 1 cyc");

   property p_prog;
      @(posedge clk) disable iff (!rstn)
      state_reg == CIX_PROG && irq_event |=> state_reg == CIX_DONE;
   endproperty
   a_prog: assert property (p_prog) else $error("program not ended");

   property p_dest;
      @(posedge clk) disable iff (!rstn)
      idle_issue && !is_complement_file_instr && !is_rotate_right_nocarry_instr && !is_clear_watchdog_instr && !is_long_call_instr
         && !is_skip && dest_sel_both |=> $stable(accumulator) && file_wr_en;
   endproperty
   a_dest: assert property (p_dest) else $error("dest select wrong");

   c_long_call_instr: cover property (@(posedge clk) idle_issue && is_long_call_instr);
   c_prog:  cover property (@(posedge clk) state_reg == CIX_PROG && irq_event);
   c_skip:  cover property (@(posedge clk) flush_fetch);
   c_three: cover property (@(posedge clk) idle_issue && is_tblrd_pcl);
endmodule
`default_nettype wire

/* dv/cix_exec_bench.sv */
// Self-checking bench for the instruction execution subset.
// Assumes cix_exec registers results one cycle after a taken issue.
`default_nettype none
module cix_exec_bench
   import cix_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // Observed vector layout: busy 53, flush 52, acc 51:44, file data 43:36,
   // file write 35, pc 34:19, zero 18, watchdog fields 17:0
   localparam logic [63:0] M_ACC = 64'hFF << 44;
   localparam logic [63:0] M_FWD = 64'hFF << 36;
   localparam logic [63:0] M_FWE = 64'h1 << 35;
   localparam logic [63:0] M_PC  = 64'hFFFF << 19;
   localparam logic [63:0] M_Z   = 64'h1 << 18;
   localparam logic [63:0] M_FL  = 64'h1 << 52;
   localparam logic [63:0] M_BZ  = 64'h1 << 53;
   localparam logic [63:0] M_WD  = 64'h3FFFF;
   // Skip taken, skip not taken, long call, read into pc low, external write
   localparam logic [5:0]  CL [5] = '{6'h30, 6'h20, 6'h08, 6'h04, 6'h02};
   // Busy cycles after the issue cycle
   localparam int          NB [5] = '{1, 0, 1, 2, 1};

   typedef struct {int at; logic [63:0] m; logic [63:0] v;} cix_note_type;

   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        issue = 1'b0;
   logic [15:0] instr = 16'h0000;
   logic [7:0]  file_rd_data = 8'h00;
   logic        dest_sel_both = 1'b0;
   logic        is_skip = 1'b0, skip_cond = 1'b0, is_flow = 1'b0;
   logic        is_tblrd_pcl = 1'b0, is_tblwt = 1'b0, tblwt_internal = 1'b0;
   logic        irq_event = 1'b0;
   logic [7:0]  pc_high_latch = 8'h00;
   logic        busy, flush_fetch, file_wr_en, zero_flag;
   logic        wdog_expiry_n, sleep_flag_n;
   logic [7:0]  accumulator, file_wr_data, wdog_count, wdog_postscale;
   logic [15:0] pc_reg;
   cix_note_type q[$];
   int          cyc = 0;
   int          miscompares = 0;
   int          n_tests = 0;
   logic [31:0] seed = 32'h12C2;

   cix_exec u_cix_exec (.clk, .rstn, .issue, .instr, .file_rd_data,
      .dest_sel_both, .is_skip, .skip_cond, .is_flow, .is_tblrd_pcl,
      .is_tblwt, .tblwt_internal, .irq_event, .pc_high_latch, .busy,
      .flush_fetch, .accumulator, .file_wr_data, .file_wr_en, .pc_reg,
      .zero_flag, .wdog_count, .wdog_postscale, .wdog_expiry_n,
      .sleep_flag_n);

   always #10 clk = ~clk;

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   function automatic logic [63:0] f(input logic [15:0] x, input int lsb);
      return 64'(x) << lsb;
   endfunction

   function automatic logic [63:0] obs();
      return {10'h000, busy, flush_fetch, accumulator, file_wr_data,
              file_wr_en, pc_reg, zero_flag, wdog_count, wdog_postscale,
              wdog_expiry_n, sleep_flag_n};
   endfunction

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic note(input int at, input logic [63:0] m,
                       input logic [63:0] v);
      q.push_back('{at, m, v & m});
   endtask

   // Notes must be pushed in cycle order; the monitor only looks at the front
   always @(negedge clk) begin
      while (q.size() > 0 && q[0].at == cyc) begin
         check(obs() & q[0].m, q[0].v);
         void'(q.pop_front());
      end
      cyc <= cyc + 1;
   end

   // Issue stays up until the first edge of the following idle call
   task automatic op(input logic [15:0] w, input logic [7:0] fv,
                     input logic [5:0] cls, output int t);
      @(posedge clk);
      t = cyc;
      issue <= 1'b1;
      instr <= w;
      file_rd_data <= fv;
      dest_sel_both <= w[DEST_BIT];
      {is_skip, skip_cond, is_flow, is_tblrd_pcl, is_tblwt,
       tblwt_internal} <= cls;
   endtask

   task automatic idle(input int n);
      repeat (n) begin
         @(posedge clk);
         issue <= 1'b0;
      end
   endtask

   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      int         t;
      logic [7:0] v, r, am;
      logic       zm, rot;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      t = cyc;
      note(t, M_BZ | M_ACC | M_PC | M_Z | 64'h3, 64'h3);
      am = 8'h00;
      zm = 1'b0;
      idle(1);
      $display("Reset values done");
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         rot = i[2];
         v = (i < 2) ? 8'hFF : seed[7:0];
         r = rot ? {v[0], v[7:1]} : ~v;
         if (!rot)
            zm = (r == 8'h00);
         op({rot ? OP_ROTATE_RIGHT_NOCARRY_INSTR : OP_COMPLEMENT_FILE_INSTR, i[0], seed[15:8]}, v, 6'h00, t);
         if (i[0])
            note(t + 1, M_FWD | M_FWE | M_Z | M_ACC,
                 f(r, 36) | f(1, 35) | f(zm, 18) | f(am, 44));
         else
            note(t + 1, M_ACC | M_Z, f(r, 44) | f(zm, 18));
         if (!i[0])
            am = r;
         idle(2);
      end
      $display("Complement and rotate done");
      // Generic path: s=0 writes both, then s=1 leaves accumulator alone
      for (int s = 0; s < 2; s++) begin
         seed = xs(seed);
         op({7'h00, s[0], 8'h00}, seed[7:0], 6'h00, t);
         note(t + 1, M_FWD | M_FWE | M_ACC, f(seed[7:0], 36) | f(1, 35)
              | f(s[0] ? am : seed[7:0], 44));
         if (s == 0)
            am = seed[7:0];
         idle(2);
      end
      $display("Destination select done");
      // Let the counter wrap so the postscaler is nonzero before clearing
      idle(260);
      op(OP_CLEAR_WATCHDOG_INSTR, 8'h00, 6'h00, t);
      note(t + 1, M_WD, f(1, 1) | f(1, 0));
      idle(2);
      $display("Watchdog clear done");
      for (int k = 0; k < 5; k++) begin
         seed = xs(seed);
         pc_high_latch <= seed[23:16];
         op((k == 2) ? {OP_LONG_CALL_INSTR, seed[7:0]} : 16'h0000, seed[15:8], CL[k], t);
         note(t, M_FL, f(k == 0, 52));
         for (int j = 1; j <= NB[k] + 1; j++)
            note(t + j, M_BZ | ((k == 2 && j == 1) ? M_PC : 64'h0),
                 f(j <= NB[k], 53) | f({seed[23:16], seed[7:0]}, 19));
         idle(NB[k] + 1);
      end
      $display("Cycle counts done");
      op(16'h0000, 8'h00, 6'h03, t);
      for (int j = 1; j <= 4; j++)
         note(t + j, M_BZ, M_BZ);
      idle(4);
      @(posedge clk);
      irq_event <= 1'b1;
      for (int j = 0; j < 40 && busy !== 1'b0; j++)
         @(negedge clk);
      check(64'(busy), 64'h0);
      @(posedge clk);
      irq_event <= 1'b0;
      idle(3);
      $display("Internal table write done");
      summarize();
   end
endmodule
`default_nettype wire
